/* hw/mcr_consts.vh */
// Purpose: Constants for chopper timing and load-adaptive current scaling
// Assumes: 50 MHz core_clk, word-indexed register port
// Notes:   Register index is printed value; chopper config lives at own index
//
// Contract
// - Hysteresis chopper decodes low field bits 10:7 as -3..12, units 1/512.
// - Off-time mode uses same field as sine offset -3..12 added to magnitude.
// - Hysteresis start bits 6:4 decode 1..8, added to low for start hysteresis.
// - Active hysteresis decrements by one every 16 clocks.
// - Off-time mode fast decay is 32 times {msb,6:4} clocks; zero means none.
// - Slow decay lasts 24 plus 32 times off-time field clocks.
// - Off-time field zero disables driver, all bridges off.
// - Filter bit 24 set updates load value once per four full steps.
// - Stall threshold bits 22:16 is signed -64..+63.
// - Minimum-current bit 15 limits reduction to half or quarter of run current.
// - Down-speed bits 14:13 decrement once per 32, 8, 2 or 1 values.
// - Load at or above (low+hyst+1)*32 decreases current.
// - Up-step bits 6:5 give increment 1, 2, 4 or 8.
// - Load below low limit times 32 increases current.
// - Zero lower limit switches load-adaptive control off.
// - Chopper select bit 14 picks hysteresis (0) or constant off time (1).
// - Bit 11 is fast decay time msb in off-time mode.
// - Blanking bits 16:15 select 16, 24, 36 or 54 clocks.
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH
`define MCR_IDX_CHOP_CONF   8'h6C
`define MCR_IDX_LOAD_CONF   8'h6D
`define MCR_IDX_STATUS      8'h6E
`define MCR_CHOP_RESET      32'h0000_0000
`define MCR_LOAD_RESET      32'h0000_0000
`define MCR_LOAD_MASK       32'h017F_EF6F
`define MCR_CHOP_MASK       32'h0001_CFFF
`define MCR_F_SLOW_LO       0
`define MCR_F_HSTART_LO     4
`define MCR_F_HLOW_LO       7
`define MCR_F_FDMSB         11
`define MCR_F_CHM           14
`define MCR_F_BLANK_LO      15
`define MCR_F_SEMIN_LO      0
`define MCR_F_SEUP_LO       5
`define MCR_F_SEMAX_LO      8
`define MCR_F_SEDN_LO       13
`define MCR_F_SEIMIN        15
`define MCR_F_SGT_LO        16
`define MCR_F_SFILT         24
`define MCR_HYST_DEC_CYC    5'd16
`define MCR_OFF_BASE_CYC    10'd24
`define MCR_CYC_UNIT        10'd32
`define MCR_HLOW_BIAS       6'd3
`define MCR_FILT_STEPS      2'd3
`define MCR_BLANK0          6'd16
`define MCR_BLANK1          6'd24
`define MCR_BLANK2          6'd36
`define MCR_BLANK3          6'd54
`endif

/* hw/mcr_chop.v */
// Purpose: Chopper phase timer: on, fast decay, slow decay, hysteresis decay
// Assumes: Current comparator input synchronous to core_clk
// Notes:   Bridge drive is a phase code; 0 means all bridges off
`timescale 1ns/10ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_chop (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Configuration
  input  wire [31:0] chop_cfg,
  // Comparator
  input  wire        cur_reached,
  // Outputs
  output reg  [1:0]  bridge_phase_q,
  output reg  [4:0]  hyst_active_q,
  output reg  [4:0]  sine_offset_q,
  output reg         driver_en_q
);
  localparam ST_OFF = 4'b0001;
  localparam ST_ON  = 4'b0010;
  localparam ST_FD  = 4'b0100;
  localparam ST_SD  = 4'b1000;
  reg  [3:0] state_q;
  reg  [9:0] cnt_q;
  reg  [3:0] hdiv_q;
  wire [3:0] slow_decay_time  = chop_cfg[`MCR_F_SLOW_LO+3:`MCR_F_SLOW_LO];
  wire [2:0] hysteresis_start = chop_cfg[`MCR_F_HSTART_LO+2:`MCR_F_HSTART_LO];
  wire [3:0] hysteresis_low   = chop_cfg[`MCR_F_HLOW_LO+3:`MCR_F_HLOW_LO];
  wire       chm              = chop_cfg[`MCR_F_CHM];
  wire [1:0] blanking_time    = chop_cfg[`MCR_F_BLANK_LO+1:`MCR_F_BLANK_LO];
  wire [3:0] fast_decay_time  = {chop_cfg[`MCR_F_FDMSB], hysteresis_start};
  wire [9:0] off_cyc = `MCR_OFF_BASE_CYC + {1'b0, slow_decay_time, 5'b0};
  wire [9:0] fd_cyc  = {1'b0, fast_decay_time, 5'b0};
  // Hysteresis kept in offset form: low+3 plus start+1 (range up to 23)
  wire [4:0] hyst_start = {1'b0, hysteresis_low} + {2'b0, hysteresis_start} + 5'd1;
  reg  [5:0] blank_cyc;
  always @* begin
    case (blanking_time)
      2'd0:    blank_cyc = `MCR_BLANK0;
      2'd1:    blank_cyc = `MCR_BLANK1;
      2'd2:    blank_cyc = `MCR_BLANK2;
      default: blank_cyc = `MCR_BLANK3;
    endcase
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q        <= ST_OFF;
      cnt_q          <= 10'h000;
      hdiv_q         <= 4'h0;
      bridge_phase_q <= 2'h0;
      hyst_active_q  <= 5'h00;
      sine_offset_q  <= 5'h00;
      driver_en_q    <= 1'b0;
    end else begin
      sine_offset_q <= chm ? {1'b0, hysteresis_low} : 5'h00;
      hdiv_q        <= hdiv_q + 4'h1;
      // Off-time mode has no hysteresis; clear at once so it never drops later
      if (chm)
        hyst_active_q <= 5'h00;
      else if (hdiv_q == 4'hF && hyst_active_q > {1'b0, hysteresis_low})
        hyst_active_q <= hyst_active_q - 5'h01;
      if (slow_decay_time == 4'h0) begin
        state_q        <= ST_OFF;
        bridge_phase_q <= 2'h0;
        driver_en_q    <= 1'b0;
      end else begin
        driver_en_q <= 1'b1;
        case (state_q)
          ST_OFF: begin
            state_q        <= ST_ON;
            cnt_q          <= 10'h000;
            bridge_phase_q <= 2'h1;
            hyst_active_q  <= chm ? 5'h00 : hyst_start;
            hdiv_q         <= 4'h0;
          end
          ST_ON: begin
            cnt_q <= cnt_q + 10'h001;
            // Comparator ignored during blanking to skip switching spikes
            if (cnt_q >= {4'h0, blank_cyc} && cur_reached) begin
              cnt_q <= 10'h000;
              if (chm && fd_cyc != 10'h000) begin
                state_q        <= ST_FD;
                bridge_phase_q <= 2'h2;
              end else begin
                state_q        <= ST_SD;
                bridge_phase_q <= 2'h3;
              end
            end
          end
          ST_FD: begin
            cnt_q <= cnt_q + 10'h001;
            if (cnt_q + 10'h001 >= fd_cyc) begin
              cnt_q          <= 10'h000;
              state_q        <= ST_SD;
              bridge_phase_q <= 2'h3;
            end
          end
          ST_SD: begin
            cnt_q <= cnt_q + 10'h001;
            if (cnt_q + 10'h001 >= off_cyc) begin
              cnt_q          <= 10'h000;
              state_q        <= ST_ON;
              bridge_phase_q <= 2'h1;
              hyst_active_q  <= chm ? 5'h00 : hyst_start;
              // Step timer restarts so each on phase gets full 16-clock steps
              hdiv_q         <= 4'h0;
            end
          end
          default: state_q <= ST_OFF;
        endcase
      end
    end
  end
endmodule // mcr_chop
`default_nettype wire

/* hw/mcr_adapt.v */
// Purpose: Load-adaptive current scale stepping
// Assumes: load_valid pulses once per new load measurement
// Notes:   Scale is 5 bits like run current
`timescale 1ns/10ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_adapt (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Configuration
  input  wire [31:0] load_cfg,
  input  wire [4:0]  run_current,
  // Load measurement
  input  wire        load_valid,
  input  wire [9:0]  load_value,
  // Outputs
  output reg  [4:0]  cur_scale_q
);
  wire [3:0] semin  = load_cfg[`MCR_F_SEMIN_LO+3:`MCR_F_SEMIN_LO];
  wire [1:0] seup   = load_cfg[`MCR_F_SEUP_LO+1:`MCR_F_SEUP_LO];
  wire [3:0] semax  = load_cfg[`MCR_F_SEMAX_LO+3:`MCR_F_SEMAX_LO];
  wire [1:0] sedn   = load_cfg[`MCR_F_SEDN_LO+1:`MCR_F_SEDN_LO];
  wire       seimin = load_cfg[`MCR_F_SEIMIN];
  wire [10:0] lo_thr = {2'b0, semin, 5'b0};
  wire [10:0] hi_thr = {1'b0, {1'b0, semin} + {1'b0, semax} + 5'd1, 5'b0};
  wire [4:0]  min_cur = seimin ? {2'b0, run_current[4:2]} : {1'b0, run_current[4:1]};
  wire [5:0]  up_step = 6'd1 << seup;
  reg  [4:0]  dn_div;
  reg  [4:0]  dn_cnt_q;
  wire [5:0]  up_sum = {1'b0, cur_scale_q} + up_step;
  always @* begin
    case (sedn)
      2'd0:    dn_div = 5'd31;
      2'd1:    dn_div = 5'd7;
      2'd2:    dn_div = 5'd1;
      default: dn_div = 5'd0;
    endcase
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_scale_q <= 5'h00;
      dn_cnt_q    <= 5'h00;
    end else if (semin == 4'h0) begin
      cur_scale_q <= run_current;
      dn_cnt_q    <= 5'h00;
    end else if (cur_scale_q > run_current) begin
      cur_scale_q <= run_current;
    end else if (cur_scale_q < min_cur) begin
      cur_scale_q <= min_cur;
    end else if (load_valid) begin
      if ({1'b0, load_value} < lo_thr) begin
        dn_cnt_q    <= 5'h00;
        cur_scale_q <= (up_sum > {1'b0, run_current}) ? run_current : up_sum[4:0];
      end else if ({1'b0, load_value} >= hi_thr) begin
        if (dn_cnt_q >= dn_div) begin
          dn_cnt_q <= 5'h00;
          if (cur_scale_q > min_cur)
            cur_scale_q <= cur_scale_q - 5'h01;
        end else begin
          dn_cnt_q <= dn_cnt_q + 5'h01;
        end
      end
    end
  end
endmodule // mcr_adapt
`default_nettype wire

/* hw/mcr_top.v */
// Purpose: Register port, load filter and stall compare around chopper and adaptive scale
// Assumes: Load measurement and full-step strobe from logic on core_clk
// Notes:   Comparator pin is synchronised; read data valid one cycle after strobe
`timescale 1ns/10ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_top (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  // Motor side
  input  wire [4:0]  run_current,
  input  wire        cur_cmp_pin,
  input  wire        load_meas_valid,
  input  wire [9:0]  load_meas,
  input  wire        full_step,
  output wire [1:0]  bridge_phase,
  output wire        driver_en,
  output wire [4:0]  hyst_active,
  output wire [4:0]  sine_offset,
  output wire [4:0]  cur_scale,
  output reg         stall_q,
  output reg  [9:0]  load_filt_q
);
  reg  [31:0] chop_cfg_q;
  reg  [31:0] load_cfg_q;
  reg         cmp_s1_q;
  reg         cmp_s2_q;
  reg  [1:0]  fs_cnt_q;
  reg         filt_valid_q;
  wire        sfilt = load_cfg_q[`MCR_F_SFILT];
  wire signed [6:0] sgt = load_cfg_q[`MCR_F_SGT_LO+6:`MCR_F_SGT_LO];
  // Stall when load plus threshold*32 reaches zero: a higher threshold needs more torque
  wire signed [12:0] stall_thr = 13'h0000 - {sgt[6], sgt, 5'h00};
  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chop_cfg_q  <= `MCR_CHOP_RESET;
      load_cfg_q  <= `MCR_LOAD_RESET;
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `MCR_IDX_CHOP_CONF)
        chop_cfg_q <= reg_wdata & `MCR_CHOP_MASK;
      if (reg_wr && reg_addr == `MCR_IDX_LOAD_CONF)
        load_cfg_q <= reg_wdata & `MCR_LOAD_MASK;
      reg_rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `MCR_IDX_CHOP_CONF: reg_rdata_q <= chop_cfg_q;
          `MCR_IDX_LOAD_CONF: reg_rdata_q <= load_cfg_q;
          `MCR_IDX_STATUS:    reg_rdata_q <= {load_filt_q, 1'b0, stall_q, driver_en,
                                              cur_scale, hyst_active, bridge_phase, 7'h00};
          default:            reg_rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ------------------------------------------------------------
  // Comparator sync, load filter, stall compare
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_q     <= 1'b0;
      cmp_s2_q     <= 1'b0;
      fs_cnt_q     <= 2'h0;
      filt_valid_q <= 1'b0;
      load_filt_q  <= 10'h000;
      stall_q      <= 1'b0;
    end else begin
      cmp_s1_q     <= cur_cmp_pin;
      cmp_s2_q     <= cmp_s1_q;
      filt_valid_q <= 1'b0;
      if (full_step)
        fs_cnt_q <= fs_cnt_q + 2'h1;
      if (load_meas_valid && (!sfilt || (full_step && fs_cnt_q == `MCR_FILT_STEPS))) begin
        load_filt_q  <= load_meas;
        filt_valid_q <= 1'b1;
        stall_q      <= $signed({3'b000, load_meas}) <= stall_thr;
      end
    end
  end
  mcr_chop u_chop (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .chop_cfg       (chop_cfg_q),
    .cur_reached    (cmp_s2_q),
    .bridge_phase_q (bridge_phase),
    .hyst_active_q  (hyst_active),
    .sine_offset_q  (sine_offset),
    .driver_en_q    (driver_en)
  );
  mcr_adapt u_adapt (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .load_cfg    (load_cfg_q),
    .run_current (run_current),
    .load_valid  (filt_valid_q),
    .load_value  (load_filt_q),
    .cur_scale_q (cur_scale)
  );
endmodule // mcr_top
`default_nettype wire

/* tb/mcr_top_props.sv */
// Purpose: Port checks for mcr_top
// Assumes: run_current held steady by the bench
// Notes:   Step checks skip 7 cycles after a write
`timescale 1ns/10ps
`default_nettype none
module mcr_top_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  // Motor side
  input wire logic [4:0]  run_current,
  input wire logic [1:0]  bridge_phase,
  input wire logic        driver_en,
  input wire logic [4:0]  hyst_active,
  input wire logic [4:0]  cur_scale
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // A config write may legally make values jump
  logic [2:0] quiet_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) quiet_q <= 3'h0;
    else if (reg_wr) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  wire logic quiet = (quiet_q == 3'h7);
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0) else $error("read data outside answer");
  a_off_bridges:
    assert property (!driver_en |-> bridge_phase == 2'h0) else $error("bridges driven while disabled");
  a_scale_max:
    assert property (cur_scale <= run_current) else $error("scale above run current");
  a_scale_min:
    assert property (quiet |-> cur_scale >= (run_current >> 2)) else $error("scale below quarter");
  a_scale_down:
    assert property (quiet && cur_scale < $past(cur_scale) |-> $past(cur_scale) - cur_scale == 5'h01)
      else $error("scale fell by more than one");
  a_scale_up:
    assert property (quiet && cur_scale > $past(cur_scale) |-> cur_scale - $past(cur_scale) <= 5'h08)
      else $error("scale rose by more than eight");
  a_fast_then_slow:
    assert property (quiet && $past(bridge_phase) == 2'h2 && bridge_phase != 2'h2 |-> bridge_phase == 2'h3)
      else $error("fast decay not followed by slow decay");
  a_slow_len:
    assert property (quiet && $changed(bridge_phase) && bridge_phase == 2'h3 |-> (bridge_phase == 2'h3)[*8])
      else $error("slow decay too short");
  a_hyst_step:
    assert property (quiet && hyst_active < $past(hyst_active) |-> $past(hyst_active) - hyst_active == 5'h01)
      else $error("hysteresis fell by more than one");
endmodule // mcr_top_props
bind mcr_top mcr_top_props u_props (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .run_current(run_current), .bridge_phase(bridge_phase),
  .driver_en(driver_en), .hyst_active(hyst_active), .cur_scale(cur_scale));
`default_nettype wire

/* tb/mcr_motor_model.sv */
// Purpose: Bridge current and load measurement stand-in
// Assumes: Phase code 1 means bridges driving
// Notes:   Load value is inverted between samples, never held
`timescale 1ns/10ps
`default_nettype none
module mcr_motor_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Bridge drive and knobs
  input  wire logic [1:0] bridge_phase,
  input  wire logic [7:0] cmp_delay,
  input  wire logic [9:0] load_lvl,
  // Sense returns
  output logic            cur_cmp_pin,
  output logic            load_meas_valid,
  output logic [9:0]      load_meas,
  output logic            full_step
);
  logic [7:0] on_cnt_q;
  logic [4:0] tick_q;
  // A long cmp_delay models a slowly rising coil current
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt_q <= 8'h00;
      tick_q <= 5'h00;
      cur_cmp_pin <= 1'b0;
      load_meas_valid <= 1'b0;
      load_meas <= 10'h000;
      full_step <= 1'b0;
    end else begin
      on_cnt_q <= (bridge_phase != 2'h1) ? 8'h00 : on_cnt_q + {7'h00, on_cnt_q != 8'hFF};
      cur_cmp_pin <= (bridge_phase == 2'h1) && (on_cnt_q >= cmp_delay);
      tick_q <= tick_q + 5'h01;
      // Two full steps per sample, one beside it, so a filter takes every other sample
      full_step <= (tick_q[3:0] == 4'hF);
      load_meas_valid <= (tick_q == 5'h1F);
      load_meas <= (tick_q == 5'h1F) ? load_lvl : ~load_lvl;
    end
  end
endmodule // mcr_motor_model
`default_nettype wire

/* tb/mcr_top_bench.sv */
// Purpose: Self-checking bench for mcr_top
// Assumes: run_current held at one level
// Notes:   Load samples arrive every 32 clocks
`timescale 1ns/10ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_top_bench;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, cmp_delay = 8'h04;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q;
  logic [4:0] run_current = 5'h14, hyst_active, sine_offset, cur_scale;
  logic [9:0] load_lvl = 10'h000, load_meas, load_filt_q;
  logic cur_cmp_pin, load_meas_valid, full_step, driver_en, stall_q;
  logic [1:0] bridge_phase;
  logic [3:0] off_set, fd_set, low_set;
  int n_fail = 0, total_checks = 0, seed = 72, n;
  int per [4] = '{32, 8, 2, 1};
  int blank [4] = '{16, 24, 36, 54};
  always #10 core_clk = ~core_clk;
  mcr_top dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .run_current,
    .cur_cmp_pin, .load_meas_valid, .load_meas, .full_step, .bridge_phase, .driver_en, .hyst_active,
    .sine_offset, .cur_scale, .stall_q, .load_filt_q);
  mcr_motor_model u_motor (.core_clk, .rst_n, .bridge_phase, .cmp_delay, .load_lvl, .cur_cmp_pin,
    .load_meas_valid, .load_meas, .full_step);
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    chk(reg_rdata_q, e);
    tick();
  endtask
  // Length of the next complete stay in phase p
  task automatic ph_len(input logic [1:0] p, output int len);
    len = 0;
    for (int i = 0; i < 3000 && bridge_phase === p; i++) tick();
    for (int i = 0; i < 3000 && bridge_phase !== p; i++) tick();
    while (bridge_phase === p && len < 3000) begin
      len++;
      tick();
    end
  endtask
  // Scale settles two cycles after the sample
  task automatic samples(input int k);
    for (int j = 0; j < k;) begin
      tick();
      if (load_meas_valid === 1'b1) j++;
    end
    repeat (3) tick();
  endtask
  function automatic logic [31:0] chop(input logic m, input logic [1:0] tb, input logic [3:0] fd, he, of);
    return {15'h0, tb, m, 2'h0, fd[3], he, fd[2:0], of};
  endfunction
  function automatic logic [31:0] cool(input logic [6:0] sg, input logic mn, input logic [1:0] dn, up,
                                       input logic [3:0] lo);
    return {9'h0, sg, mn, dn, 1'b0, 4'h1, 1'b0, up, 1'b0, lo};
  endfunction
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    tick();
    rd(`MCR_IDX_LOAD_CONF, `MCR_LOAD_RESET);
    rd(`MCR_IDX_CHOP_CONF, `MCR_CHOP_RESET);
    repeat (4) begin
      n = $random(seed);
      wr(`MCR_IDX_LOAD_CONF, n);
      rd(`MCR_IDX_LOAD_CONF, n & `MCR_LOAD_MASK);
      wr(8'h20, n);
      rd(8'h20, 32'h0);
    end
    wr(`MCR_IDX_CHOP_CONF, chop(1'b0, 2'h1, 4'h3, 4'h5, 4'h0));
    rd(`MCR_IDX_CHOP_CONF, chop(1'b0, 2'h1, 4'h3, 4'h5, 4'h0));
    repeat (3) tick();
    chk(driver_en, 1'b0);
    chk(bridge_phase, 2'h0);
    for (int k = 0; k < 4; k++) begin
      off_set = 4'h2 + 4'({$random(seed)} % 14);
      fd_set = 4'h1 + 4'({$random(seed)} % 15);
      low_set = 4'({$random(seed)} % 12);
      cmp_delay <= 8'hC8;
      wr(`MCR_IDX_CHOP_CONF, chop(1'b0, 2'(k), fd_set, low_set, off_set));
      ph_len(2'h3, n);
      chk(n, 24 + 32 * off_set);
      repeat (2) tick();
      chk(hyst_active, low_set + fd_set[2:0] + 1);
      repeat (190) tick();
      chk(hyst_active, low_set);
      chk(driver_en, 1'b1);
      cmp_delay <= 8'h04;
      wr(`MCR_IDX_CHOP_CONF, chop(1'b1, 2'(k), fd_set, low_set, off_set));
      ph_len(2'h2, n);
      chk(n, 32 * fd_set);
      chk(sine_offset, low_set);
      // Comparator is high early, so the on phase lasts the blanking time plus one
      ph_len(2'h1, n);
      chk(n, blank[k] + 1);
    end
    load_lvl <= 10'd40;
    wr(`MCR_IDX_LOAD_CONF, cool(7'h02, 1'b0, 2'h3, 2'h3, 4'h2));
    samples(8);
    chk(cur_scale, 5'h14);
    chk(stall_q, 1'b0);
    chk(load_filt_q, 10'd40);
    for (int c = 0; c < 4; c++) begin
      wr(`MCR_IDX_LOAD_CONF, cool(7'h7E, 1'b0, 2'(c), 2'(c), 4'h2));
      load_lvl <= 10'd200;
      samples(4 * per[c]);
      chk(cur_scale, 5'h10);
      load_lvl <= 10'd40;
      samples(1);
      chk(cur_scale, (c >= 2) ? 5'h14 : 5'h10 + (5'h01 << c));
      chk(stall_q, 1'b1);
      samples(4);
    end
    load_lvl <= 10'd200;
    samples(16);
    chk(cur_scale, 5'h0A);
    wr(`MCR_IDX_LOAD_CONF, cool(7'h02, 1'b1, 2'h3, 2'h0, 4'h2));
    samples(8);
    chk(cur_scale, 5'h05);
    wr(`MCR_IDX_LOAD_CONF, cool(7'h02, 1'b0, 2'h3, 2'h0, 4'h0) | 32'h0100_0000);
    samples(2);
    chk(cur_scale, 5'h14);
    // Filtered: of two fresh samples exactly one may land
    load_lvl <= 10'd60;
    samples(1);
    n = (load_filt_q === 10'd60);
    load_lvl <= 10'd80;
    samples(1);
    n += (load_filt_q === 10'd80);
    chk(n, 1);
    test_done();
  end
  initial begin
    #1000000;
    n_fail++;
    test_done();
  end
endmodule // mcr_top_bench
`default_nettype wire
